//--- logic/buck_seq_pkg.sv
`default_nettype none
package buck_seq_pkg;
    // Clock and nominal times, ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_DELAY_NS = 6_800_000;
    localparam int CAPTURE_MAX_NS = 3_400_000;
    localparam int SOFT_START_NS = 6_800_000;
    // Ramp shape
    localparam int SS_STEPS = 64;
    localparam int CAPTURE_STEPS = 64;
    localparam int INIT_STEPS = 1;
    localparam int DUMMY_TIMEOUTS = 2;
    // Derived cycle counts, step times rounded down
    localparam int DELAY_CYCLES = INIT_DELAY_NS / CLK_PERIOD_NS;
    localparam int SS_STEP_CYCLES = SOFT_START_NS / SS_STEPS / CLK_PERIOD_NS;
    localparam int CAP_STEP_CYCLES =
        CAPTURE_MAX_NS / CAPTURE_STEPS / CLK_PERIOD_NS;
    localparam int DUMMY_TICKS = DUMMY_TIMEOUTS * SS_STEPS;
    // Widths and reset values
    localparam int TIMER_W = 17;
    localparam int RAMP_W = 7;
    localparam int DUMMY_W = 8;
    localparam logic [RAMP_W-1:0] RAMP_RESET = 7'h00;

    // Sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_CAPTURE = 3'b010,
        ST_SOFTSTART = 3'b011,
        ST_RUN = 3'b100,
        ST_HICCUP = 3'b101
    } seq_state_t;

    // Gate drive pins travel together
    typedef struct packed {
        logic high_side;
        logic low_out;
        logic low_oe;
    } gate_drive_t;
endpackage : buck_seq_pkg
`default_nettype wire

//--- logic/buck_startup_sequencer.sv
// Overview of operation
// R01 - Supply rise starts init with trip capture
// R02 - Held shutdown pin postpones initialization
// R03 - Fixed delay starts when pin released
// R04 - Delay: low driver off, trip current on
// R05 - Capture time variable, up to maximum
// R06 - Trip value held in counter register
// R07 - Soft-start follows capture immediately
// R08 - Reference ramps zero to final value
// R09 - Ramp is 64 equal fixed steps
// R10 - Error amplifier enabled after short interval
// R11 - Ramp past final value ends soft-start
// R12 - Low pre-bias: gates off until crossed
// R13 - High pre-bias: gates off until end
// R14 - Re-enable repeats full init with capture
// R15 - Overcurrent retries keep held trip value
// R16 - Overcurrent restarts after two dummy timeouts
// R17 - High gate waits for low gate off
// R18 - Shutdown stops, gates low, re-arms start
// R19 - Overcurrent hiccup repeats while fault persists
// R20 - Gates low through delay and capture
// R21 - Power loss resets and discards trip value
`default_nettype none
module buck_startup_sequencer
    import buck_seq_pkg::*;
#(
    parameter int DELAY_CYC = DELAY_CYCLES,
    parameter int SS_STEP_CYC = SS_STEP_CYCLES,
    parameter int CAP_STEP_CYC = CAP_STEP_CYCLES,
    parameter int DAC_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Analog comparators
    input wire logic por_ok,
    input wire logic shutdown_above,
    input wire logic trip_reached,
    input wire logic ramp_above_vout,
    input wire logic overcurrent,
    // Modulator and gate sense
    input wire logic pwm_high,
    input wire logic low_side_gate_sense_in,
    // Gate pins and analog controls
    output var gate_drive_t gate,
    output logic trip_source_en,
    output logic osc_run,
    output logic erramp_enable,
    output logic [RAMP_W-1:0] ramp_code,
    output logic [DAC_W-1:0] trip_level,
    output logic soft_start_done
);
    seq_state_t state;
    seq_state_t next_state;
    logic [TIMER_W-1:0] timer;
    logic [DUMMY_W-1:0] dummy_cnt;
    logic [DAC_W-1:0] dac;
    logic switch_ok;
    logic tick;
    logic ramp_top;
    logic dac_top;
    logic gate_allow;

    // Step tick per phase; the delay is one long count
    always_comb begin
        case (state)
            ST_DELAY: tick = (timer == TIMER_W'(DELAY_CYC - 1));
            ST_CAPTURE: tick = (timer == TIMER_W'(CAP_STEP_CYC - 1));
            ST_SOFTSTART, ST_HICCUP: begin
                tick = (timer == TIMER_W'(SS_STEP_CYC - 1));
            end
            default: tick = 1'b0;
        endcase
    end
    assign ramp_top = (ramp_code == RAMP_W'(SS_STEPS - 1));
    assign dac_top = (dac == {DAC_W{1'b1}});

    // Phase sequencing
    always_comb begin
        next_state = state;
        case (state)
            // R02 waits for release
            ST_IDLE: begin
                if (shutdown_above) begin
                    next_state = ST_DELAY;
                end
            end
            // R03 fixed delay
            ST_DELAY: begin
                if (tick) begin
                    next_state = ST_CAPTURE;
                end
            end
            // R05 variable capture, R07 then start
            ST_CAPTURE: begin
                if (trip_reached || (tick && dac_top)) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (overcurrent) begin
                    next_state = ST_HICCUP;
                end else if (tick && ramp_top) begin
                    // R11 ramp past final
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (overcurrent) begin
                    next_state = ST_HICCUP;
                end
            end
            // R16 two dummy timeouts, R19 repeats
            ST_HICCUP: begin
                if (tick && dummy_cnt == DUMMY_W'(DUMMY_TICKS - 1)) begin
                    next_state = ST_SOFTSTART;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // R18 shutdown re-arms from any phase
        // R14 release then repeats full init
        if (!shutdown_above) begin
            next_state = ST_IDLE;
        end
    end

    // State register; R21 power loss, R01 rise starts
    always_ff @(posedge clock) begin
        if (srst || !por_ok) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycle timer restarts on each tick or phase change
    always_ff @(posedge clock) begin
        if (srst || state != next_state || tick) begin
            timer <= '0;
        end else begin
            timer <= timer + TIMER_W'(1);
        end
    end

    // Dummy timeout counter for retries
    always_ff @(posedge clock) begin
        if (srst || state != ST_HICCUP) begin
            dummy_cnt <= '0;
        end else if (tick) begin
            dummy_cnt <= dummy_cnt + DUMMY_W'(1);
        end
    end

    // R08 R09 ramp of equal steps, restarted each entry
    always_ff @(posedge clock) begin
        if (srst || (state != ST_SOFTSTART && state != ST_RUN)) begin
            ramp_code <= RAMP_RESET;
        end else if (state == ST_SOFTSTART && tick) begin
            ramp_code <= ramp_code + RAMP_W'(1);
        end
    end

    // Capture counter climbs until the comparator trips
    always_ff @(posedge clock) begin
        if (srst || state != ST_CAPTURE) begin
            dac <= '0;
        end else if (tick && !dac_top && !trip_reached) begin
            dac <= dac + DAC_W'(1);
        end
    end

    // R06 held value; R15 only capture exit loads it; R21 cleared
    always_ff @(posedge clock) begin
        if (srst || !por_ok) begin
            trip_level <= '0;
        end else if (state == ST_CAPTURE && next_state == ST_SOFTSTART) begin
            trip_level <= dac;
        end
    end

    // R12 R13 switching held off until ramp crosses output or run begins
    always_ff @(posedge clock) begin
        if (srst || (state != ST_SOFTSTART && state != ST_RUN)) begin
            switch_ok <= 1'b0;
        end else if (ramp_above_vout || state == ST_RUN) begin
            switch_ok <= 1'b1;
        end
    end

    // Analog controls; R04 trip current only in delay and capture
    always_ff @(posedge clock) begin
        if (srst) begin
            trip_source_en <= 1'b0;
            osc_run <= 1'b0;
            erramp_enable <= 1'b0;
            soft_start_done <= 1'b0;
        end else begin
            trip_source_en <= (state == ST_DELAY || state == ST_CAPTURE);
            osc_run <= (state != ST_IDLE); // R18 oscillator stops
            // R10 amplifier on after the first step
            erramp_enable <= (state == ST_RUN) || (state == ST_SOFTSTART
                && ramp_code >= RAMP_W'(INIT_STEPS));
            soft_start_done <= (state == ST_RUN);
        end
    end

    // R18 R19 switching only while ramping or regulating; a
    // stale switch_ok must not drive gates in idle or retry
    assign gate_allow = switch_ok && por_ok && !overcurrent
        && next_state == state
        && (state == ST_SOFTSTART || state == ST_RUN);

    // Gate drivers; the sense pin is only read while the low driver is
    // enabled; delay and capture release it so the trip voltage is undisturbed
    always_ff @(posedge clock) begin
        if (srst) begin
            gate <= '0;
        end else begin
            // R04 R20 low driver released, both gates low
            gate.low_oe <= !(state == ST_DELAY || state == ST_CAPTURE);
            // R17 high side only once low gate sensed off
            gate.high_side <= gate_allow && pwm_high
                && !gate.low_out && !low_side_gate_sense_in;
            gate.low_out <= gate_allow && !pwm_high && !gate.high_side;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_GATES_OFF_INIT: assert property ( // R20
        (state == ST_DELAY || state == ST_CAPTURE)
        |=> !gate.high_side && !gate.low_out)
        else $error("gate driven during delay or capture");
    AST_TRIP_SOURCE: assert property ( // R04
        (state == ST_DELAY) |=> trip_source_en && !gate.low_oe)
        else $error("trip current or low driver wrong in delay");
    AST_DELAY_LEN: assert property ( // R03
        (state == ST_CAPTURE && $past(state) == ST_DELAY)
        |-> $past(timer) == TIMER_W'(DELAY_CYC - 1))
        else $error("delay length wrong");
    AST_SHUTDOWN: assert property ( // R18
        (!shutdown_above && state != ST_IDLE)
        |=> state == ST_IDLE ##1 !osc_run && !gate.high_side)
        else $error("shutdown not honoured");
    AST_POR_LOSS: assert property ( // R21
        !por_ok |=> state == ST_IDLE && trip_level == '0)
        else $error("power loss did not reset");
    AST_OC_HICCUP: assert property ( // R16
        (state inside {ST_SOFTSTART, ST_RUN} && overcurrent
        && shutdown_above && por_ok) |=> state == ST_HICCUP)
        else $error("overcurrent did not start retry");
    AST_HICCUP_LEN: assert property ( // R19
        (state == ST_SOFTSTART && $past(state) == ST_HICCUP)
        |-> $past(dummy_cnt) == DUMMY_W'(DUMMY_TICKS - 1))
        else $error("retry left early");
    AST_NO_RECAPTURE: assert property ( // R15
        (state == ST_HICCUP && por_ok) |=> $stable(trip_level))
        else $error("trip value changed in retry");
    AST_RAMP_STEP: assert property ( // R09
        (state == ST_SOFTSTART && $past(state) == ST_SOFTSTART
        && ramp_code != $past(ramp_code))
        |-> ramp_code == $past(ramp_code) + RAMP_W'(1))
        else $error("ramp step not one");
    AST_SS_END: assert property ( // R11
        (state == ST_RUN && $past(state) == ST_SOFTSTART)
        |-> ramp_code == RAMP_W'(SS_STEPS))
        else $error("soft-start ended at wrong step");
    AST_SHOOT: assert property ( // R17
        $rose(gate.high_side) |-> $past(!low_side_gate_sense_in))
        else $error("high gate on while low gate sensed on");
    AST_PREBIAS: assert property ( // R12
        (state == ST_SOFTSTART && !switch_ok && !ramp_above_vout)
        |=> !gate.high_side && !gate.low_out)
        else $error("switching before ramp crossed output");
    // Guards on idle, retry, soft-start, capture and run
    AST_GATES_HALTED: assert property ( // R19
        (state == ST_IDLE || state == ST_HICCUP)
        |=> !gate.high_side && !gate.low_out)
        else $error("gate driven while idle or in retry");
    AST_OSC_STOP: assert property ( // R18
        (state == ST_IDLE) |=> !osc_run && !trip_source_en)
        else $error("oscillator or trip current on while idle");
    AST_ERRAMP_WAIT: assert property ( // R10
        (state == ST_SOFTSTART && ramp_code == RAMP_RESET)
        |=> !erramp_enable)
        else $error("amplifier enabled before first step");
    AST_CAPTURE_MAX: assert property ( // R05
        (state == ST_CAPTURE && tick && dac_top)
        |=> state != ST_CAPTURE)
        else $error("capture ran past full scale");
    AST_RECAPTURE: assert property ( // R14
        (state == ST_SOFTSTART && $past(state) == ST_CAPTURE)
        |-> trip_level == $past(dac))
        else $error("capture exit did not load trip value");
    AST_RUN_HOLD: assert property ( // R11
        (state == ST_RUN) |=> soft_start_done
        && ramp_code == RAMP_W'(SS_STEPS))
        else $error("run without final ramp step");

    // Main scenarios
    COV_RUN: cover property (state == ST_SOFTSTART ##1 state == ST_RUN);
    COV_HICCUP: cover property (state == ST_HICCUP ##1
        state == ST_SOFTSTART);
    COV_PREBIAS: cover property (state == ST_RUN && !$past(switch_ok));
    COV_RESTART: cover property (state == ST_RUN ##1 state == ST_IDLE);
    COV_CAPTURE_FULL: cover property (state == ST_CAPTURE && dac_top && tick);
endmodule : buck_startup_sequencer
`default_nettype wire

//--- bench/half_bridge_model.sv
`default_nettype none
module half_bridge_model
    import buck_seq_pkg::*;
(
    // Clock
    input wire logic clock,
    // From the controller and the bench
    input wire gate_drive_t gate,
    input wire logic hold_low,
    // Pin levels back to the controller, shoot-through flag to the bench
    output logic low_sense,
    output logic shutdown_above,
    output logic shoot_through
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] rise_cnt = 2'h0;
    // resistor to ground pulls the released pin
    assign low_sense = gate.low_oe & gate.low_out;
    // both switches on would short the supply
    assign shoot_through = gate.high_side & low_sense;
    // pin charges slowly, so crossing lags release
    always_ff @(posedge clock) begin
        if (hold_low) rise_cnt <= 2'h0;
        else if (rise_cnt != 2'h3) rise_cnt <= rise_cnt + 2'h1;
    end
    assign shutdown_above = (rise_cnt == 2'h3);
endmodule : half_bridge_model
`default_nettype wire

//--- bench/buck_startup_sequencer_tb.sv
`default_nettype none
module buck_startup_sequencer_tb
    import buck_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 20;
    localparam int SSC = 4;
    // Signals a bounded wait can watch
    localparam int W_TRIP = 0;
    localparam int W_RAMP = 1;
    localparam int W_HIGH = 2;
    localparam int W_DONE = 3;
    logic clock = 1'b0, srst = 1'b1, por_ok = 1'b0, trip_reached = 1'b0;
    logic ramp_above_vout = 1'b0, overcurrent = 1'b0, pwm_en = 1'b0;
    logic hold_low = 1'b1, pwm_high, low_sense, shutdown_above, shoot;
    logic [2:0] pwm_cnt = 3'h0;
    gate_drive_t gate;
    logic trip_source_en, osc_run, erramp_enable, soft_start_done;
    logic [RAMP_W-1:0] ramp_code;
    logic [5:0] trip_level;
    int n_errors = 0, cmp_count = 0, n;
    buck_startup_sequencer #(.DELAY_CYC(DLY), .SS_STEP_CYC(SSC),
        .CAP_STEP_CYC(3), .DAC_W(6)) dut (.clock(clock), .srst(srst),
        .por_ok(por_ok), .shutdown_above(shutdown_above),
        .trip_reached(trip_reached), .ramp_above_vout(ramp_above_vout),
        .overcurrent(overcurrent), .pwm_high(pwm_high),
        .low_side_gate_sense_in(low_sense), .gate(gate),
        .trip_source_en(trip_source_en), .osc_run(osc_run),
        .erramp_enable(erramp_enable), .ramp_code(ramp_code),
        .trip_level(trip_level), .soft_start_done(soft_start_done));
    half_bridge_model bridge (.clock(clock), .gate(gate),
        .hold_low(hold_low), .low_sense(low_sense),
        .shutdown_above(shutdown_above), .shoot_through(shoot));
    // Clock and a slow modulator demand
    initial begin
        forever #50 clock = ~clock;
    end
    always @(negedge clock) pwm_cnt <= pwm_cnt + 3'h1;
    assign pwm_high = pwm_en & pwm_cnt[2];
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    function automatic logic watched(input int w);
        case (w)
            W_TRIP: return trip_source_en;
            W_RAMP: return ramp_code[0];
            W_HIGH: return gate.high_side;
            default: return soft_start_done;
        endcase
    endfunction : watched
    // Bounded wait; a hang ends the run
    task automatic wait_sig(input int w, input logic v, input int lim);
        for (n = 0; n < lim && watched(w) !== v; n++) @(negedge clock);
        if (watched(w) !== v) begin
            n_errors++;
            $display("timeout at %0t", $time);
            tally_and_finish();
        end
    endtask : wait_sig
    task automatic t_power_up();
        por_ok = 1'b1;
        trip_reached = 1'b1;
        repeat (30) @(negedge clock);
        check(osc_run, 1'b0);
        hold_low = 1'b0;
        wait_sig(W_TRIP, 1'b1, 40);
        for (n = 0; n < 300 && trip_source_en === 1'b1; n++) begin
            if (n == 5) check(32'(gate), 32'h0);
            @(negedge clock);
        end
        // fixed delay then one capture cycle
        check(n >= DLY && n <= DLY + 3, 1'b1);
        $display("power up done");
    endtask : t_power_up
    task automatic t_high_prebias();
        pwm_en = 1'b1;
        wait_sig(W_RAMP, 1'b1, 40);
        // amplifier still off on the first step
        check(erramp_enable, 1'b0);
        for (n = 0; n < 400 && soft_start_done !== 1'b1; n++) begin
            // no switching while output above ramp
            check(gate.high_side | gate.low_out, 1'b0);
            if (n == 1) check(erramp_enable, 1'b1);
            @(negedge clock);
        end
        check(n >= 63 * SSC - 2 && n <= 63 * SSC + 2, 1'b1);
        check({ramp_code, erramp_enable}, {7'h40, 1'b1});
        // held value of the quick capture
        check(trip_level, 6'h00);
        wait_sig(W_HIGH, 1'b1, 20);
        check(shoot, 1'b0);
        $display("high pre-bias done");
    endtask : t_high_prebias
    task automatic t_overcurrent();
        trip_reached = 1'b0;
        overcurrent = 1'b1;
        @(negedge clock);
        overcurrent = 1'b0;
        @(negedge clock);
        check({gate.high_side, ramp_code}, 8'h00);
        wait_sig(W_RAMP, 1'b1, 800);
        // two dummy timeouts before the ramp
        check(n >= 129 * SSC - 4 && n <= 129 * SSC + 2, 1'b1);
        check(trip_level, 6'h00);
        repeat (40) @(negedge clock);
        // gates off until the ramp passes output
        check(gate.high_side | gate.low_out, 1'b0);
        ramp_above_vout = 1'b1;
        wait_sig(W_HIGH, 1'b1, 20);
        check(soft_start_done, 1'b0);
        wait_sig(W_DONE, 1'b1, 400);
        $display("overcurrent done");
    endtask : t_overcurrent
    task automatic t_shutdown();
        hold_low = 1'b1;
        repeat (3) @(negedge clock);
        check({osc_run, gate.high_side, gate.low_out}, 3'h0);
        hold_low = 1'b0;
        wait_sig(W_DONE, 1'b1, 1500);
        // fresh capture runs to full scale
        check(trip_level, 6'h3f);
        por_ok = 1'b0;
        repeat (2) @(negedge clock);
        // power loss clears the held value
        check({osc_run, trip_level}, 7'h00);
        $display("shutdown done");
    endtask : t_shutdown
    initial begin
        repeat (6) @(negedge clock);
        srst = 1'b0;
        t_power_up();
        t_high_prebias();
        t_overcurrent();
        t_shutdown();
        tally_and_finish();
    end
endmodule : buck_startup_sequencer_tb
`default_nettype wire
